// ---- hdl/drive_ctrl_pkg.sv ----
// Package: register map, field positions, reset values and types of the drive control-source block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`default_nettype none
package drive_ctrl_pkg;
	// Register byte offsets
	localparam logic [7:0] CONTROL_WORD_OFS = 8'h00;
	localparam logic [7:0] STATUS_WORD_OFS = 8'h04;
	localparam logic [7:0] CTRL_SOURCE_OFS = 8'h08;
	localparam logic [7:0] DATASET_SEL_OFS = 8'h0c;
	localparam logic [7:0] ACTIVE_DATASET_OFS = 8'h10;
	localparam logic [7:0] CONFIG_OFS = 8'h14;
	localparam logic [7:0] MODE_REQ_OFS = 8'h18;
	localparam logic [7:0] DIGITAL_IN_OFS = 8'h1c;
	localparam logic [7:0] WARNINGS_OFS = 8'h20;
	localparam logic [7:0] MODE_ACT_OFS = 8'h24;
	localparam logic [7:0] FAULT_OFS = 8'h28;
	// Control-source selector values
	localparam logic [5:0] SRC_CONTACTS = 6'h00;
	localparam logic [5:0] SRC_STATE_MACHINE = 6'h01;
	localparam logic [5:0] SRC_VIRTUAL = 6'h02;
	localparam logic [5:0] SRC_MAX = 6'h2c;
	localparam logic [5:0] SRC_RESET = 6'h2c;
	// Data set selection
	localparam logic [2:0] DSSEL_CONTACTS = 3'h0;
	localparam logic [2:0] DSSEL_IDLE_ONLY = 3'h5;
	localparam logic [2:0] DSSEL_RESET = 3'h0;
	localparam logic [1:0] DSET_RESET = 2'h0;
	// Modes of operation (8-bit two's complement)
	localparam logic [7:0] MODE_VELOCITY = 8'h02;
	localparam logic [7:0] MODE_CLEAR_LIMIT = 8'hfe;
	localparam logic [7:0] MODE_RESET = 8'h02;
	// Control word bits and commands
	localparam int CW_SWITCH_ON = 0;
	localparam int CW_ENABLE_VOLT = 1;
	localparam int CW_QUICK_STOP_N = 2;
	localparam int CW_ENABLE_OP = 3;
	localparam int CW_FAULT_RESET = 7;
	localparam int CW_HALT = 8;
	localparam logic [3:0] CMD_SWITCH_ON = 4'h7;
	localparam logic [3:0] CMD_ENABLE_OP = 4'hf;
	localparam logic [15:0] CW_RESET = 16'h0000;
	// Status word bits
	localparam int SW_READY = 0;
	localparam int SW_SWITCHED_ON = 1;
	localparam int SW_OP_ENABLED = 2;
	localparam int SW_FAULT = 3;
	localparam int SW_VOLTAGE = 4;
	localparam int SW_QUICK_STOP_N = 5;
	localparam int SW_ON_DISABLED = 6;
	localparam int SW_WARNING = 7;
	localparam int SW_REMOTE = 9;
	localparam int SW_TARGET = 10;
	localparam int SW_LIMIT = 11;
	localparam int SW_MODE_LO = 12;
	localparam int SW_MODE_HI = 13;
	localparam int SW_WARNING2 = 15;
	// Warning readout bits
	localparam int WARN_LIMIT_CW = 0;
	localparam int WARN_LIMIT_CCW = 1;
	localparam int WARN_INTERNAL = 2;
	// Drive state machine
	typedef enum logic [2:0] {
		ST_ON_DISABLED, ST_READY, ST_SWITCHED_ON, ST_OP_ENABLED, ST_QUICK_STOP, ST_FAULT
	} drive_state_type;
	// Pins and drive-side flags that arrive together
	typedef struct packed {
		logic safe_release_a;
		logic safe_release_b;
		logic start_cw_input;
		logic start_ccw_input;
		logic [1:0] dataset_contacts;
		logic limit_cw;
		logic limit_ccw;
	} pins_type;
	typedef struct packed {
		logic mains_ok;
		logic ref_reached;
		logic pfail_zero_hz;
		logic current_limit;
		logic torque_limit;
		logic overvolt_ctrl;
		logic internal_warn;
		logic delayed_warn;
		logic mode_bit12;
		logic mode_bit13;
	} drive_flags_type;
endpackage : drive_ctrl_pkg
`default_nettype wire

// ---- hdl/pin_sync.sv ----
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes inputs are slow levels; no bus coherency across bits is promised.
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	initial begin
		if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pin_sync
`default_nettype wire

// ---- hdl/drive_ctrl_source.sv ----
// Drive control-source selection, data set choice, release gating, limit lockout and status word.
// Assumes a classic Wishbone master on CLK; pins are asynchronous and synchronised here.
//
// Operation
// - Tripped limit blocks its direction, raises fault
// - After reset, travel allowed in free direction
// - Limit warning held while switch tripped
// - Mode minus two moves off limit
// - Selector: 0 contacts, 1 state machine, 2 virtual
// - Positioning modes only under state machine
// - Selector per data set, remote bit follows
// - Selection 0 uses contacts, 1-4 force set
// - Selection 5 switches only while not enabled
// - Active data set reported as 1 to 4
// - Virtual start needs both releases and bit0
// - Release input readback needs both plus bit0
// - Contact sources permit velocity mode only
// - Status bit4 mains present, else no start
// - Status bit7 flags internal warning
// - Bit10 on reference reached or zero Hz
// - Bit11 while any internal limit active
// - Bit15 on delayed pre-trip warning
// - Enable needs both releases, plus start without positioning
// - Control word acts only under state machine; bit0 still drives virtual start and readback
// - Bits 4-6 and halt only in motion control
// - Bit14 unused; bits 12-13 only positioning
// - Switch-on processed only with mains present
// - Enable waits in switched-on for release
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`default_nettype none
module drive_ctrl_source #(
	parameter int DATASETS = 4
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// Wishbone slave
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	// Asynchronous pins
	input wire drive_ctrl_pkg::pins_type PINS,
	// Drive-side flags, same clock
	input wire drive_ctrl_pkg::drive_flags_type FLAGS,
	// Drive commands
	output logic RUN_ENABLE,
	output logic ALLOW_CW,
	output logic ALLOW_CCW,
	output logic [7:0] MODE_ACTIVE,
	output logic [15:0] STATUS_WORD,
	output logic [1:0] DATASET_ACTIVE
);
	initial begin
		if (DATASETS != 4) $error("drive_ctrl_source: DATASETS must be 4");
	end

	localparam int PW = $bits(drive_ctrl_pkg::pins_type);

	drive_ctrl_pkg::pins_type pins_s;
	logic [PW-1:0] pins_raw;
	assign pins_raw = PINS;

	pin_sync #(.WIDTH(PW)) u_sync (
		.clk(CLK),
		.rst_n(RSTN),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	// Software-written and internal state
	logic [15:0] cw_q;
	logic [5:0] src_q [DATASETS];
	logic [2:0] dssel_q;
	logic motion_cfg_q;
	logic [7:0] mode_req_q;
	logic [1:0] dset_q;
	drive_ctrl_pkg::drive_state_type state_q;
	logic fault_q;
	logic fault_rst_prev_q;
	logic ack_q;
	logic [31:0] dat_q;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
		merge16 = old;
		if (sel[0]) merge16[7:0] = d[7:0];
		if (sel[1]) merge16[15:8] = d[15:8];
	endfunction : merge16

	// Derived source and gates
	logic [5:0] src;
	logic by_sm, by_contacts, by_virtual, both_release, start_in, limit_any;
	logic [15:0] cw_eff;
	assign src = src_q[dset_q];
	assign by_sm = (src == drive_ctrl_pkg::SRC_STATE_MACHINE);
	assign by_contacts = (src == drive_ctrl_pkg::SRC_CONTACTS);
	assign by_virtual = (src == drive_ctrl_pkg::SRC_VIRTUAL);
	assign both_release = pins_s.safe_release_a & pins_s.safe_release_b;
	assign start_in = pins_s.start_cw_input | pins_s.start_ccw_input;
	assign limit_any = pins_s.limit_cw | pins_s.limit_ccw;
	// Ignored unless state machine holds control
	assign cw_eff = by_sm ? cw_q : drive_ctrl_pkg::CW_RESET;

	logic bus_req, bus_wr;
	assign bus_req = CYC_I & STB_I & ~ack_q;
	assign bus_wr = bus_req & WE_I;

	// Bus-written registers
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cw_q <= drive_ctrl_pkg::CW_RESET;
			for (int i = 0; i < DATASETS; i++) begin
				src_q[i] <= drive_ctrl_pkg::SRC_RESET;
			end
			dssel_q <= drive_ctrl_pkg::DSSEL_RESET;
			motion_cfg_q <= 1'b0;
			mode_req_q <= drive_ctrl_pkg::MODE_RESET;
		end else if (bus_wr) begin
			case (ADR_I)
				drive_ctrl_pkg::CONTROL_WORD_OFS: cw_q <= merge16(cw_q, DAT_I, SEL_I);
				drive_ctrl_pkg::CTRL_SOURCE_OFS: begin
					// Writes the selector of the data set now active; out-of-range ignored
					if (SEL_I[0] && DAT_I[7:0] <= {2'b00, drive_ctrl_pkg::SRC_MAX}) begin
						src_q[dset_q] <= DAT_I[5:0];
					end
				end
				drive_ctrl_pkg::DATASET_SEL_OFS: begin
					if (SEL_I[0] && DAT_I[7:0] <= {5'b0, drive_ctrl_pkg::DSSEL_IDLE_ONLY}) begin
						dssel_q <= DAT_I[2:0];
					end
				end
				drive_ctrl_pkg::CONFIG_OFS: begin
					if (SEL_I[0]) motion_cfg_q <= DAT_I[0];
				end
				drive_ctrl_pkg::MODE_REQ_OFS: begin
					if (SEL_I[0]) mode_req_q <= DAT_I[7:0];
				end
				default: ;
			endcase
		end
	end

	// Data set choice
	logic drive_enabled;
	assign drive_enabled = (state_q == drive_ctrl_pkg::ST_OP_ENABLED);
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			dset_q <= drive_ctrl_pkg::DSET_RESET;
		end else if (dssel_q == drive_ctrl_pkg::DSSEL_CONTACTS) begin
			dset_q <= pins_s.dataset_contacts;
		end else if (dssel_q == drive_ctrl_pkg::DSSEL_IDLE_ONLY) begin
			// Frozen in operation enabled so a state-machine run cannot change source mid-motion
			if (!drive_enabled) dset_q <= pins_s.dataset_contacts;
		end else begin
			dset_q <= 2'(dssel_q - 3'h1);
		end
	end

	// Effective mode of operation
	logic [7:0] mode_d;
	always_comb begin
		mode_d = mode_req_q;
		if (!by_sm || !motion_cfg_q) begin
			mode_d = drive_ctrl_pkg::MODE_VELOCITY;
		end
	end

	// Device state machine, driven by the control word
	logic [3:0] cmd;
	logic fault_edge, limit_trip;
	assign cmd = cw_eff[3:0];
	assign fault_edge = cw_eff[drive_ctrl_pkg::CW_FAULT_RESET] & ~fault_rst_prev_q;
	logic lim_prev_q;
	assign limit_trip = limit_any & ~lim_prev_q;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			fault_rst_prev_q <= 1'b0;
			lim_prev_q <= 1'b0;
		end else begin
			fault_rst_prev_q <= cw_eff[drive_ctrl_pkg::CW_FAULT_RESET];
			lim_prev_q <= limit_any;
		end
	end

	// Limit trip raises the fault; trip wins over a simultaneous reset
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			fault_q <= 1'b0;
		end else if (limit_trip) begin
			fault_q <= 1'b1;
		end else if (fault_edge || (!by_sm && !limit_any)) begin
			fault_q <= 1'b0;
		end
	end

	logic release_ok;
	assign release_ok = both_release & (motion_cfg_q | start_in);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= drive_ctrl_pkg::ST_ON_DISABLED;
		end else if (fault_q) begin
			state_q <= drive_ctrl_pkg::ST_FAULT;
		end else if (!by_sm) begin
			state_q <= drive_ctrl_pkg::ST_ON_DISABLED;
		end else begin
			case (state_q)
				drive_ctrl_pkg::ST_ON_DISABLED: begin
					if (cmd[2:0] == 3'h6) state_q <= drive_ctrl_pkg::ST_READY;
				end
				drive_ctrl_pkg::ST_READY: begin
					if (!cmd[1] || !cmd[2]) state_q <= drive_ctrl_pkg::ST_ON_DISABLED;
					else if (cmd == drive_ctrl_pkg::CMD_SWITCH_ON && FLAGS.mains_ok) begin
						state_q <= drive_ctrl_pkg::ST_SWITCHED_ON;
					end
				end
				drive_ctrl_pkg::ST_SWITCHED_ON: begin
					if (!cmd[1] || !cmd[2]) state_q <= drive_ctrl_pkg::ST_ON_DISABLED;
					else if (!cmd[0]) state_q <= drive_ctrl_pkg::ST_READY;
					else if (cmd == drive_ctrl_pkg::CMD_ENABLE_OP && release_ok && FLAGS.mains_ok) begin
						state_q <= drive_ctrl_pkg::ST_OP_ENABLED;
					end
				end
				drive_ctrl_pkg::ST_OP_ENABLED: begin
					if (!cmd[1]) state_q <= drive_ctrl_pkg::ST_ON_DISABLED;
					else if (!cmd[2]) state_q <= drive_ctrl_pkg::ST_QUICK_STOP;
					else if (!cmd[0]) state_q <= drive_ctrl_pkg::ST_READY;
					else if (!cmd[3] || !release_ok) state_q <= drive_ctrl_pkg::ST_SWITCHED_ON;
				end
				drive_ctrl_pkg::ST_QUICK_STOP: begin
					if (!cmd[1]) state_q <= drive_ctrl_pkg::ST_ON_DISABLED;
				end
				drive_ctrl_pkg::ST_FAULT: begin
					state_q <= drive_ctrl_pkg::ST_ON_DISABLED;
				end
				default: state_q <= drive_ctrl_pkg::ST_ON_DISABLED;
			endcase
		end
	end

	// Run permission for each source
	logic virt_start, contact_start, run_d;
	assign virt_start = both_release & cw_q[drive_ctrl_pkg::CW_SWITCH_ON];
	assign contact_start = both_release & start_in;
	always_comb begin
		run_d = 1'b0;
		if (!fault_q && FLAGS.mains_ok) begin
			// Release loss stops the run at the same edge as the state machine leaves operation enabled
			if (by_sm) run_d = drive_enabled & both_release;
			else if (by_virtual) run_d = virt_start;
			else if (by_contacts) run_d = contact_start;
		end
	end

	// Status word assembly
	logic [15:0] sw_d;
	always_comb begin
		sw_d = '0;
		case (state_q)
			drive_ctrl_pkg::ST_ON_DISABLED: sw_d[drive_ctrl_pkg::SW_ON_DISABLED] = 1'b1;
			drive_ctrl_pkg::ST_READY: sw_d[5:0] = 6'h21;
			drive_ctrl_pkg::ST_SWITCHED_ON: sw_d[5:0] = 6'h23;
			drive_ctrl_pkg::ST_OP_ENABLED: sw_d[5:0] = 6'h27;
			drive_ctrl_pkg::ST_QUICK_STOP: sw_d[5:0] = 6'h07;
			drive_ctrl_pkg::ST_FAULT: sw_d[drive_ctrl_pkg::SW_FAULT] = 1'b1;
			default: sw_d = '0;
		endcase
		sw_d[drive_ctrl_pkg::SW_VOLTAGE] = FLAGS.mains_ok;
		sw_d[drive_ctrl_pkg::SW_WARNING] = FLAGS.internal_warn | limit_any;
		sw_d[drive_ctrl_pkg::SW_REMOTE] = by_sm & both_release;
		sw_d[drive_ctrl_pkg::SW_TARGET] = FLAGS.ref_reached | FLAGS.pfail_zero_hz;
		sw_d[drive_ctrl_pkg::SW_LIMIT] = FLAGS.current_limit | FLAGS.torque_limit
			| FLAGS.overvolt_ctrl;
		// Bit 14 stays zero
		if (motion_cfg_q) begin
			sw_d[drive_ctrl_pkg::SW_MODE_LO] = FLAGS.mode_bit12;
			sw_d[drive_ctrl_pkg::SW_MODE_HI] = FLAGS.mode_bit13;
		end
		sw_d[drive_ctrl_pkg::SW_WARNING2] = FLAGS.delayed_warn;
	end

	// Digital input readback
	logic [7:0] din;
	always_comb begin
		din = '0;
		din[0] = both_release & cw_q[drive_ctrl_pkg::CW_SWITCH_ON];
		din[1] = pins_s.start_cw_input;
		din[2] = pins_s.start_ccw_input;
		din[5:4] = pins_s.dataset_contacts;
	end

	// Motion-control bits of the control word, used only in that configuration
	logic [3:0] mc_bits;
	assign mc_bits = motion_cfg_q ? {cw_eff[drive_ctrl_pkg::CW_HALT], cw_eff[6:4]} : 4'h0;

	// Registered outputs
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			RUN_ENABLE <= 1'b0;
			ALLOW_CW <= 1'b0;
			ALLOW_CCW <= 1'b0;
			MODE_ACTIVE <= drive_ctrl_pkg::MODE_RESET;
			STATUS_WORD <= '0;
			DATASET_ACTIVE <= drive_ctrl_pkg::DSET_RESET;
		end else begin
			// Halt stops motion only where motion control reads it
			RUN_ENABLE <= run_d & ~mc_bits[3];
			// Direction lockout; clear-limit mode uses the same free direction
			ALLOW_CW <= run_d & ~pins_s.limit_cw;
			ALLOW_CCW <= run_d & ~pins_s.limit_ccw;
			MODE_ACTIVE <= mode_d;
			STATUS_WORD <= sw_d;
			DATASET_ACTIVE <= dset_q;
		end
	end

	// Wishbone read and ack: one wait state, ack for one cycle
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= bus_req;
			dat_q <= '0;
			if (bus_req && !WE_I) begin
				case (ADR_I)
					drive_ctrl_pkg::CONTROL_WORD_OFS: dat_q <= {16'h0000, cw_q};
					drive_ctrl_pkg::STATUS_WORD_OFS: dat_q <= {16'h0000, sw_d};
					drive_ctrl_pkg::CTRL_SOURCE_OFS: dat_q <= {26'h0, src};
					drive_ctrl_pkg::DATASET_SEL_OFS: dat_q <= {29'h0, dssel_q};
					drive_ctrl_pkg::ACTIVE_DATASET_OFS: dat_q <= {29'h0, 3'({1'b0, dset_q}) + 3'h1};
					drive_ctrl_pkg::CONFIG_OFS: dat_q <= {31'h0, motion_cfg_q};
					drive_ctrl_pkg::MODE_REQ_OFS: dat_q <= {24'h0, mode_req_q};
					drive_ctrl_pkg::DIGITAL_IN_OFS: dat_q <= {24'h0, din};
					drive_ctrl_pkg::WARNINGS_OFS: dat_q <= {29'h0, FLAGS.internal_warn,
						pins_s.limit_ccw, pins_s.limit_cw};
					drive_ctrl_pkg::MODE_ACT_OFS: dat_q <= {24'h0, mode_d};
					drive_ctrl_pkg::FAULT_OFS: dat_q <= {29'h0, state_q};
					default: dat_q <= '0;
				endcase
			end
		end
	end

	assign ACK_O = ack_q;
	assign DAT_O = dat_q;
endmodule : drive_ctrl_source
`default_nettype wire

// ---- tb/drive_ctrl_assertions.sv ----
// Checker for the drive control-source block: bus timing, status bits, lockout and release gating.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module drive_ctrl_assertions (
	// Clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// Bus
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic ACK_O,
	// Pins and flags
	input wire drive_ctrl_pkg::pins_type PINS,
	input wire drive_ctrl_pkg::drive_flags_type FLAGS,
	// Outputs
	input wire logic RUN_ENABLE,
	input wire logic ALLOW_CW,
	input wire logic ALLOW_CCW,
	input wire logic [15:0] STATUS_WORD
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	ack_one_cycle_a: assert property (ACK_O |=> !ACK_O)
		else $error("ack longer than one cycle");
	ack_wait_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("request not answered next cycle");
	voltage_bit_a: assert property (STATUS_WORD[4] == $past(FLAGS.mains_ok))
		else $error("status bit 4 wrong");
	target_bit_a: assert property (STATUS_WORD[10] == $past(FLAGS.ref_reached || FLAGS.pfail_zero_hz))
		else $error("status bit 10 wrong");
	limit_bit_a: assert property (STATUS_WORD[11] ==
		$past(FLAGS.current_limit || FLAGS.torque_limit || FLAGS.overvolt_ctrl)) else $error("status bit 11 wrong");
	warn_bit_a: assert property ($past(FLAGS.internal_warn) |-> STATUS_WORD[7])
		else $error("status bit 7 missing");
	warn_two_a: assert property (STATUS_WORD[15] == $past(FLAGS.delayed_warn))
		else $error("status bit 15 wrong");
	unused_bit_a: assert property (!STATUS_WORD[14])
		else $error("status bit 14 set");
	limit_cw_a: assert property (PINS.limit_cw [*4] |-> !ALLOW_CW)
		else $error("cw allowed on tripped limit");
	limit_ccw_a: assert property (PINS.limit_ccw [*4] |-> !ALLOW_CCW)
		else $error("ccw allowed on tripped limit");
	release_gate_a: assert property ((!PINS.safe_release_a || !PINS.safe_release_b) [*4] |-> !RUN_ENABLE)
		else $error("run without both releases");
endmodule : drive_ctrl_assertions
`default_nettype wire

// ---- tb/wb_master_model.sv ----
// Controller model: classic Wishbone master writing control words and reading registers.
// Assumes one transfer at a time, requested by the bench through xfer.
`default_nettype none
module wb_master_model (
	// Clock
	input wire logic clk,
	// Request
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	// Answer
	input wire logic ack
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0;
	end
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		dat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		cyc <= 1'b0;
		stb <= 1'b0;
		// Released lines must not keep looking valid
		adr <= ~a;
		dat <= ~d;
	endtask : xfer
endmodule : wb_master_model
`default_nettype wire

// ---- tb/drive_ctrl_source_bench.sv ----
// Self-checking bench for the drive control-source block.
// Assumes the controller model and checker files are compiled before it.
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_mismatch++; \
	$display("BAD %s expected %h seen %h", n, e, s); end end
module drive_ctrl_source_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, cyc, stb, we, ack_o, run_en, allow_cw, allow_ccw;
	logic [7:0] adr, mode_act;
	logic [3:0] sel;
	logic [31:0] dat_i, dat_o, e_v, m_v, r;
	logic [31:0] rng = 32'h2e7b7206;
	logic [31:0] eq[$], mq[$];
	logic [15:0] status, sx;
	logic [1:0] dset;
	drive_ctrl_pkg::pins_type pins = '0;
	drive_ctrl_pkg::drive_flags_type flags = '0;
	int n_mismatch = 0, n_compared = 0, cycles = 0;
	drive_ctrl_source u_drive_ctrl_source (.CLK(clk), .RSTN(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack_o), .PINS(pins), .FLAGS(flags),
		.RUN_ENABLE(run_en), .ALLOW_CW(allow_cw), .ALLOW_CCW(allow_ccw), .MODE_ACTIVE(mode_act),
		.STATUS_WORD(status), .DATASET_ACTIVE(dset));
	wb_master_model u_wb_master_model (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.dat(dat_i), .ack(ack_o));
	function logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : rnd
	task finish_test();
		if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task wr(input logic [7:0] a, input logic [31:0] d);
		u_wb_master_model.xfer(1'b1, a, d);
	endtask : wr
	// Expected read value is noted before the cycle starts
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		eq.push_back(e);
		mq.push_back(m);
		u_wb_master_model.xfer(1'b0, a, 32'h0);
	endtask : rd
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end
	always @(posedge clk) if (ack_o === 1'b1 && we === 1'b0) begin
		e_v = eq.pop_front();
		m_v = mq.pop_front();
		`CHK("read data", e_v & m_v, dat_o & m_v)
	end
	initial begin
		rst_n = 1'b0;
		tick(4);
		rst_n <= 1'b1;
		tick(2);
		rd(drive_ctrl_pkg::CTRL_SOURCE_OFS, 32'h2c, 32'h3f);
		rd(drive_ctrl_pkg::DATASET_SEL_OFS, 32'h0, 32'h7);
		rd(8'h3c, 32'h0, 32'hffffffff);
		rd(drive_ctrl_pkg::MODE_ACT_OFS, 32'h2, 32'hff);
		`CHK("mode active", 8'h02, mode_act)
		wr(drive_ctrl_pkg::CTRL_SOURCE_OFS, 32'h2d);
		rd(drive_ctrl_pkg::CTRL_SOURCE_OFS, 32'h2c, 32'h3f);
		wr(drive_ctrl_pkg::DATASET_SEL_OFS, 32'h6);
		rd(drive_ctrl_pkg::DATASET_SEL_OFS, 32'h0, 32'h7);
		for (int i = 0; i < 4; i++) begin
			pins.dataset_contacts <= i[1:0];
			tick(5);
			rd(drive_ctrl_pkg::ACTIVE_DATASET_OFS, 32'(i + 1), 32'h7);
			`CHK("data set", i[1:0], dset)
		end
		for (int i = 1; i < 5; i++) begin
			r = rnd();
			wr(drive_ctrl_pkg::DATASET_SEL_OFS, 32'(i));
			pins.dataset_contacts <= r[1:0];
			tick(5);
			rd(drive_ctrl_pkg::ACTIVE_DATASET_OFS, 32'(i), 32'h7);
		end
		// Selector lives per data set, remote bit follows it
		wr(drive_ctrl_pkg::DATASET_SEL_OFS, 32'h2);
		wr(drive_ctrl_pkg::CTRL_SOURCE_OFS, 32'h1);
		pins.safe_release_a <= 1'b1;
		pins.safe_release_b <= 1'b1;
		tick(5);
		rd(drive_ctrl_pkg::STATUS_WORD_OFS, 32'h200, 32'h200);
		wr(drive_ctrl_pkg::DATASET_SEL_OFS, 32'h3);
		tick(2);
		rd(drive_ctrl_pkg::CTRL_SOURCE_OFS, 32'h2c, 32'h3f);
		rd(drive_ctrl_pkg::STATUS_WORD_OFS, 32'h0, 32'h200);
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			flags <= r[9:0];
			sx = {r[2], 3'h0, |r[6:4], r[8] | r[7], 2'h0, r[3], 2'h0, r[9], 4'h0};
			tick(2);
			rd(drive_ctrl_pkg::STATUS_WORD_OFS, {16'h0, sx}, 32'hff90);
			`CHK("status word", sx & 16'hff90, status & 16'hff90)
		end
		wr(drive_ctrl_pkg::CTRL_SOURCE_OFS, 32'h2);
		flags <= 10'h200;
		for (int i = 0; i < 8; i++) begin
			pins.safe_release_a <= i[0];
			pins.safe_release_b <= i[1];
			wr(drive_ctrl_pkg::CONTROL_WORD_OFS, {31'h0, i[2]});
			tick(5);
			rd(drive_ctrl_pkg::DIGITAL_IN_OFS, {31'h0, i[0] & i[1] & i[2]}, 32'h1);
			`CHK("virtual run", i[0] & i[1] & i[2], run_en)
		end
		// State machine source, mains absent first
		wr(drive_ctrl_pkg::DATASET_SEL_OFS, 32'h2);
		pins.safe_release_a <= 1'b0;
		pins.safe_release_b <= 1'b0;
		flags <= '0;
		wr(drive_ctrl_pkg::CONTROL_WORD_OFS, 32'h6);
		wr(drive_ctrl_pkg::CONTROL_WORD_OFS, 32'h7);
		tick(2);
		rd(drive_ctrl_pkg::FAULT_OFS, 32'h1, 32'h7);
		flags.mains_ok <= 1'b1;
		wr(drive_ctrl_pkg::CONTROL_WORD_OFS, 32'h7);
		tick(2);
		rd(drive_ctrl_pkg::FAULT_OFS, 32'h2, 32'h7);
		wr(drive_ctrl_pkg::CONTROL_WORD_OFS, 32'hf);
		tick(5);
		rd(drive_ctrl_pkg::FAULT_OFS, 32'h2, 32'h7);
		pins.safe_release_a <= 1'b1;
		pins.safe_release_b <= 1'b1;
		tick(5);
		wr(drive_ctrl_pkg::CONTROL_WORD_OFS, 32'hf);
		tick(2);
		rd(drive_ctrl_pkg::FAULT_OFS, 32'h2, 32'h7);
		pins.start_cw_input <= 1'b1;
		tick(5);
		wr(drive_ctrl_pkg::CONTROL_WORD_OFS, 32'hf);
		tick(5);
		rd(drive_ctrl_pkg::FAULT_OFS, 32'h3, 32'h7);
		`CHK("run enable", 1'b1, run_en)
		// Trip the cw limit, then reset the fault while it stays tripped
		pins.limit_cw <= 1'b1;
		tick(5);
		rd(drive_ctrl_pkg::FAULT_OFS, 32'h5, 32'h7);
		rd(drive_ctrl_pkg::WARNINGS_OFS, 32'h1, 32'h3);
		`CHK("cw in fault", 1'b0, allow_cw)
		wr(drive_ctrl_pkg::CONTROL_WORD_OFS, 32'h86);
		wr(drive_ctrl_pkg::CONTROL_WORD_OFS, 32'h87);
		wr(drive_ctrl_pkg::CONTROL_WORD_OFS, 32'h8f);
		tick(5);
		rd(drive_ctrl_pkg::FAULT_OFS, 32'h3, 32'h7);
		`CHK("ccw allowed", 1'b1, allow_ccw)
		`CHK("cw blocked", 1'b0, allow_cw)
		pins.limit_cw <= 1'b0;
		tick(5);
		rd(drive_ctrl_pkg::WARNINGS_OFS, 32'h0, 32'h3);
		`CHK("cw allowed", 1'b1, allow_cw)
		wr(drive_ctrl_pkg::CONFIG_OFS, 32'h1);
		wr(drive_ctrl_pkg::MODE_REQ_OFS, 32'hfe);
		tick(2);
		rd(drive_ctrl_pkg::MODE_ACT_OFS, 32'hfe, 32'hff);
		`CHK("mode active", 8'hfe, mode_act)
		wr(drive_ctrl_pkg::CONTROL_WORD_OFS, 32'h18f);
		tick(3);
		`CHK("halt", 1'b0, run_en)
		// Selection 5 holds the data set while enabled
		pins.dataset_contacts <= 2'h3;
		wr(drive_ctrl_pkg::DATASET_SEL_OFS, 32'h5);
		tick(5);
		rd(drive_ctrl_pkg::ACTIVE_DATASET_OFS, 32'h2, 32'h7);
		wr(drive_ctrl_pkg::CONTROL_WORD_OFS, 32'h86);
		tick(5);
		rd(drive_ctrl_pkg::ACTIVE_DATASET_OFS, 32'h4, 32'h7);
		wr(drive_ctrl_pkg::DATASET_SEL_OFS, 32'h3);
		tick(2);
		rd(drive_ctrl_pkg::MODE_ACT_OFS, 32'h2, 32'hff);
		`CHK("mode forced", 8'h02, mode_act)
		pins.limit_ccw <= 1'b1;
		tick(5);
		rd(drive_ctrl_pkg::WARNINGS_OFS, 32'h2, 32'h3);
		rd(drive_ctrl_pkg::STATUS_WORD_OFS, 32'h80, 32'h80);
		`CHK("ccw blocked", 1'b0, allow_ccw)
		tick(3);
		finish_test();
	end
endmodule : drive_ctrl_source_bench
bind drive_ctrl_source drive_ctrl_assertions u_drive_ctrl_assertions (.CLK(CLK), .RSTN(RSTN), .CYC_I(CYC_I),
	.STB_I(STB_I), .ACK_O(ACK_O), .PINS(PINS), .FLAGS(FLAGS), .RUN_ENABLE(RUN_ENABLE), .ALLOW_CW(ALLOW_CW),
	.ALLOW_CCW(ALLOW_CCW), .STATUS_WORD(STATUS_WORD));
`default_nettype wire
